// ==== hdl/spi5_seq_pkg.sv ====
// package: constants and state codes for the five-pin master sequencer
// assumes: used by the sequencer, its delay counter and the slave model
// Operation
// - transfer-to-select-release delay always runs its full length
// - ready drop during that delay skips ready-drop delay, goes word gap
// - ready-drop delay starts right after select-release delay
// - ready drop ends ready-drop delay early, word gap follows at once
// - ready still high when ready-drop delay expires sets slave_error_a flag
// - early ready drop holds next transfer until ready returns
// - late ready drop: next transfer starts on request, ready ignored
// - ready-drop delay absent means slave_error_a flag never set
// - select-to-transfer delay runs full; ready seen skips ready wait
// - ready wait starts after that delay; ready ends it early
// - ready still low when ready wait expires sets timeout flag
// - timeout releases select at once and drops pending request
// - ready wait absent: wait forever, never set timeout
package spi5_seq_pkg;
	localparam int dly_w = 8;
	localparam int xfer_bits = 8;
	localparam logic rst_select_n = 1'b1;
	localparam logic rst_sclk = 1'b0;
	localparam logic rst_flag = 1'b0;
	localparam logic rst_drop = 1'b1;
	localparam logic rst_tgl = 1'b0;
	localparam logic rst_link = 1'b1;

	typedef enum logic [7:0]
	{
		st_idle = 8'h01,
		st_c2t  = 8'h02,
		st_c2e  = 8'h04,
		st_wait = 8'h08,
		st_xfer = 8'h10,
		st_t2c  = 8'h20,
		st_t2e  = 8'h40,
		st_wdly = 8'h80
	} seq_state_t;
endpackage

// ==== hdl/sync_2ff.sv ====
// sync_2ff: two flip-flop level synchroniser
// assumes: din is from another domain; dout is read, meta stage is not
`timescale 1ns/10ps
module sync_2ff
#(
	parameter logic init = 1'b0
)
(
	// clock and reset
	input  wire logic clock,
	input  wire logic reset,
	// level
	input  wire logic din,
	output logic      dout
);
	logic meta_r;

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			meta_r <= init;
			dout   <= init;
		end
		else
		begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule

// ==== hdl/delay_counter.sv ====
// delay_counter: loadable down counter timing one delay period
// assumes: start pulses the cycle before the period begins
`timescale 1ns/10ps
module delay_counter
#(
	parameter int width = spi5_seq_pkg::dly_w
)
(
	// clock and reset
	input  wire logic             clock,
	input  wire logic             reset,
	// control
	input  wire logic             start,
	input  wire logic             abort,
	input  wire logic [width-1:0] len,
	// status
	output logic                  last
);
	logic [width-1:0] cnt_r;

	always_ff @(posedge clock)
	begin
		if (reset || abort)
			cnt_r <= '0;
		else if (start)
			cnt_r <= len;
		else if (cnt_r != '0)
			cnt_r <= cnt_r - 1'b1;
	end

	assign last = (cnt_r == width'(1));
endmodule

// ==== hdl/spi5_seq.sv ====
// spi5_seq: five-pin master handshake sequencer with serial clock engine
// assumes: ready line and link clock come from outside, unrelated in phase
`timescale 1ns/10ps
module spi5_seq
#(
	parameter int dly_width = spi5_seq_pkg::dly_w,
	parameter int xfer_bits = spi5_seq_pkg::xfer_bits
)
(
	// clocks and reset
	input  wire logic                 clock,
	input  wire logic                 reset,
	input  wire logic                 link_clock,
	// delay configuration
	input  wire logic [dly_width-1:0] select_to_xfer_start_delay,
	input  wire logic                 select_to_xfer_start_delay_en,
	input  wire logic [dly_width-1:0] select_to_ready_wait_limit,
	input  wire logic                 select_to_ready_wait_limit_en,
	input  wire logic [dly_width-1:0] xfer_end_to_select_release_delay,
	input  wire logic                 xfer_end_to_select_release_delay_en,
	input  wire logic [dly_width-1:0] xfer_end_to_ready_drop_delay,
	input  wire logic                 xfer_end_to_ready_drop_delay_en,
	input  wire logic [dly_width-1:0] inter_word_delay,
	input  wire logic                 inter_word_delay_en,
	// transfer request and status
	input  wire logic                 xfer_req,
	output logic                      xfer_pending,
	output logic                      xfer_done,
	output logic                      seq_busy,
	// error flags
	input  wire logic                 error_clear,
	output logic                      slave_error_a,
	output logic                      timeout_error,
	// pins
	input  wire logic                 slave_ready_line,
	output logic                      slave_select_out_n,
	output logic                      serial_clock_pin
);
	localparam int edge_w = $clog2(2 * xfer_bits) + 1;

	spi5_seq_pkg::seq_state_t state_r;
	spi5_seq_pkg::seq_state_t state_nxt;
	spi5_seq_pkg::seq_state_t pre_nxt;
	spi5_seq_pkg::seq_state_t post_nxt;
	spi5_seq_pkg::seq_state_t word_nxt;

	logic                 ready_s;
	logic                 drop_r;
	logic                 ignore_r;
	logic                 c2t_on;
	logic                 c2e_on;
	logic                 t2c_on;
	logic                 t2e_on;
	logic                 wd_on;
	logic                 dly_start;
	logic                 dly_abort;
	logic                 dly_last;
	logic [dly_width-1:0] dly_len;
	logic                 slave_error_a_set;
	logic                 timeout_set;
	logic                 take;
	logic                 start_tgl_r;
	logic                 done_s;
	logic                 done_seen_r;
	logic                 xfer_fin;
	logic [dly_width-1:0] age_r;

	// link domain
	logic                 link_reset;
	logic                 start_s;
	logic                 start_seen_r;
	logic                 running_r;
	logic [edge_w-1:0]    edge_cnt_r;
	logic                 done_tgl_r;

	// ready pin synchroniser
	sync_2ff
	#(
		.init (1'b0)
	)
	u_ready_sync
	(
		.clock (clock),
		.reset (reset),
		.din   (slave_ready_line),
		.dout  (ready_s)
	);

	// present only with enable set and nonzero length
	assign c2t_on = select_to_xfer_start_delay_en &&
		(select_to_xfer_start_delay != '0);
	assign c2e_on = select_to_ready_wait_limit_en &&
		(select_to_ready_wait_limit != '0);
	assign t2c_on = xfer_end_to_select_release_delay_en &&
		(xfer_end_to_select_release_delay != '0);
	assign t2e_on = xfer_end_to_ready_drop_delay_en &&
		(xfer_end_to_ready_drop_delay != '0);
	assign wd_on = inter_word_delay_en && (inter_word_delay != '0);

	// choices shared by several states
	always_comb
	begin
		word_nxt = wd_on ? spi5_seq_pkg::st_wdly : spi5_seq_pkg::st_idle;
		if (!drop_r || ready_s)
			pre_nxt = spi5_seq_pkg::st_xfer;
		else if (c2e_on)
			pre_nxt = spi5_seq_pkg::st_c2e;
		else
			pre_nxt = spi5_seq_pkg::st_wait;
		if (t2e_on && !drop_r && ready_s)
			post_nxt = spi5_seq_pkg::st_t2e;
		else
			post_nxt = word_nxt;
	end

	// sequencer next state
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			spi5_seq_pkg::st_idle:
				if (xfer_pending && (!drop_r || ready_s))
					state_nxt = c2t_on ? spi5_seq_pkg::st_c2t : pre_nxt;
			spi5_seq_pkg::st_c2t:
				if (dly_last)
					state_nxt = pre_nxt;
			spi5_seq_pkg::st_c2e:
				if (ready_s)
					state_nxt = spi5_seq_pkg::st_xfer;
				else if (dly_last)
					state_nxt = spi5_seq_pkg::st_idle;
			spi5_seq_pkg::st_wait:
				if (ready_s)
					state_nxt = spi5_seq_pkg::st_xfer;
			spi5_seq_pkg::st_xfer:
				if (xfer_fin)
					state_nxt = t2c_on ? spi5_seq_pkg::st_t2c : post_nxt;
			spi5_seq_pkg::st_t2c:
				if (dly_last)
					state_nxt = post_nxt;
			spi5_seq_pkg::st_t2e:
				if (!ready_s || dly_last)
					state_nxt = word_nxt;
			spi5_seq_pkg::st_wdly:
				if (dly_last)
					state_nxt = spi5_seq_pkg::st_idle;
			default:
				state_nxt = spi5_seq_pkg::st_idle;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			state_r <= spi5_seq_pkg::st_idle;
		else
			state_r <= state_nxt;
	end

	// delay period loading
	always_comb
	begin
		case (state_nxt)
			spi5_seq_pkg::st_c2t:
				dly_len = select_to_xfer_start_delay;
			spi5_seq_pkg::st_c2e:
				dly_len = select_to_ready_wait_limit;
			spi5_seq_pkg::st_t2c:
				dly_len = xfer_end_to_select_release_delay;
			spi5_seq_pkg::st_t2e:
				dly_len = xfer_end_to_ready_drop_delay;
			spi5_seq_pkg::st_wdly:
				dly_len = inter_word_delay;
			default:
				dly_len = '0;
		endcase
	end

	assign dly_start = (state_nxt != state_r) && (dly_len != '0);
	assign dly_abort = (state_nxt != state_r) && !dly_start;

	delay_counter
	#(
		.width (dly_width)
	)
	u_delay
	(
		.clock (clock),
		.reset (reset),
		.start (dly_start),
		.abort (dly_abort),
		.len   (dly_len),
		.last  (dly_last)
	);

	assign slave_error_a_set = (state_r == spi5_seq_pkg::st_t2e) && ready_s &&
		dly_last;
	assign timeout_set = (state_r == spi5_seq_pkg::st_c2e) && !ready_s &&
		dly_last;
	assign take = (state_nxt == spi5_seq_pkg::st_xfer) &&
		(state_r != spi5_seq_pkg::st_xfer);
	assign xfer_fin = done_s ^ done_seen_r;

	// early ready drop tracking
	always_ff @(posedge clock)
	begin
		if (reset)
			drop_r <= spi5_seq_pkg::rst_drop;
		else if (take)
			drop_r <= 1'b0;
		else if (!ready_s && (state_r == spi5_seq_pkg::st_xfer ||
			state_r == spi5_seq_pkg::st_t2c ||
			state_r == spi5_seq_pkg::st_t2e ||
			state_r == spi5_seq_pkg::st_wdly))
			drop_r <= 1'b1;
	end

	// ready ignored for a transfer after a late drop
	always_ff @(posedge clock)
	begin
		if (reset)
			ignore_r <= 1'b0;
		else if (state_r == spi5_seq_pkg::st_idle)
			ignore_r <= !drop_r;
	end

	// pending request, new request wins
	always_ff @(posedge clock)
	begin
		if (reset)
			xfer_pending <= 1'b0;
		else if (xfer_req)
			xfer_pending <= 1'b1;
		else if (take || timeout_set)
			xfer_pending <= 1'b0;
	end

	// error flags, set wins over clear
	always_ff @(posedge clock)
	begin
		if (reset)
			slave_error_a <= spi5_seq_pkg::rst_flag;
		else if (slave_error_a_set)
			slave_error_a <= 1'b1;
		else if (error_clear)
			slave_error_a <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			timeout_error <= spi5_seq_pkg::rst_flag;
		else if (timeout_set)
			timeout_error <= 1'b1;
		else if (error_clear)
			timeout_error <= 1'b0;
	end

	// select output and status
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			slave_select_out_n <= spi5_seq_pkg::rst_select_n;
			seq_busy           <= 1'b0;
			xfer_done          <= 1'b0;
		end
		else
		begin
			slave_select_out_n <= !(state_nxt == spi5_seq_pkg::st_c2t ||
				state_nxt == spi5_seq_pkg::st_c2e ||
				state_nxt == spi5_seq_pkg::st_wait ||
				state_nxt == spi5_seq_pkg::st_xfer ||
				state_nxt == spi5_seq_pkg::st_t2c);
			seq_busy  <= (state_nxt != spi5_seq_pkg::st_idle);
			xfer_done <= (state_r == spi5_seq_pkg::st_xfer) && xfer_fin;
		end
	end

	// crossing to and from the link engine
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			start_tgl_r <= spi5_seq_pkg::rst_tgl;
			done_seen_r <= spi5_seq_pkg::rst_tgl;
		end
		else
		begin
			start_tgl_r <= start_tgl_r ^ take;
			done_seen_r <= done_s;
		end
	end

	sync_2ff
	#(
		.init (1'b0)
	)
	u_done_sync
	(
		.clock (clock),
		.reset (reset),
		.din   (done_tgl_r),
		.dout  (done_s)
	);

	sync_2ff
	#(
		.init (spi5_seq_pkg::rst_link)
	)
	u_link_rst_sync
	(
		.clock (link_clock),
		.reset (1'b0),
		.din   (reset),
		.dout  (link_reset)
	);

	sync_2ff
	#(
		.init (1'b0)
	)
	u_start_sync
	(
		.clock (link_clock),
		.reset (link_reset),
		.din   (start_tgl_r),
		.dout  (start_s)
	);

	// serial clock engine on the link clock
	always_ff @(posedge link_clock)
	begin
		if (link_reset)
		begin
			start_seen_r     <= spi5_seq_pkg::rst_tgl;
			running_r        <= 1'b0;
			edge_cnt_r       <= '0;
			serial_clock_pin <= spi5_seq_pkg::rst_sclk;
			done_tgl_r       <= spi5_seq_pkg::rst_tgl;
		end
		else if (!running_r && (start_s != start_seen_r))
		begin
			start_seen_r <= start_s;
			running_r    <= 1'b1;
			edge_cnt_r   <= edge_w'(2 * xfer_bits - 1);
		end
		else if (running_r)
		begin
			serial_clock_pin <= ~serial_clock_pin;
			if (edge_cnt_r == '0)
			begin
				running_r  <= 1'b0;
				done_tgl_r <= ~done_tgl_r;
			end
			else
				edge_cnt_r <= edge_cnt_r - 1'b1;
		end
	end

	// cycles spent in the current state
	always_ff @(posedge clock)
	begin
		if (reset || state_nxt != state_r)
			age_r <= '0;
		else
			age_r <= age_r + 1'b1;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	sequence s_t2c_leave;
		state_r == spi5_seq_pkg::st_t2c && state_nxt != state_r;
	endsequence

	sequence s_c2t_leave;
		state_r == spi5_seq_pkg::st_c2t && state_nxt != state_r;
	endsequence

	sequence s_c2e_expire;
		state_r == spi5_seq_pkg::st_c2e && !ready_s && dly_last;
	endsequence

	property p_t2c_full;
		s_t2c_leave |->
			age_r == dly_width'(xfer_end_to_select_release_delay - 1'b1);
	endproperty
	a_t2c_full: assert property (p_t2c_full)
		else $error("select release delay cut short");

	property p_t2e_skip;
		s_t2c_leave ##0 drop_r |=> state_r != spi5_seq_pkg::st_t2e;
	endproperty
	a_t2e_skip: assert property (p_t2e_skip)
		else $error("ready drop delay not skipped");

	property p_t2e_follow;
		s_t2c_leave ##0 (t2e_on && ready_s && !drop_r)
			|=> state_r == spi5_seq_pkg::st_t2e;
	endproperty
	a_t2e_follow: assert property (p_t2e_follow)
		else $error("ready drop delay did not follow");

	property p_t2e_early;
		state_r == spi5_seq_pkg::st_t2e && !ready_s && wd_on
			|=> state_r == spi5_seq_pkg::st_wdly;
	endproperty
	a_t2e_early: assert property (p_t2e_early)
		else $error("ready drop delay not ended early");

	property p_slave_error_a;
		state_r == spi5_seq_pkg::st_t2e && ready_s && dly_last
			|=> slave_error_a;
	endproperty
	a_slave_error_a: assert property (p_slave_error_a)
		else $error("slave_error_a flag not set");

	property p_hold;
		state_r == spi5_seq_pkg::st_idle && drop_r && !ready_s
			|=> state_r == spi5_seq_pkg::st_idle;
	endproperty
	a_hold: assert property (p_hold)
		else $error("transfer started without ready");

	property p_ignore;
		state_r == spi5_seq_pkg::st_c2t && ignore_r && dly_last
			|=> state_r == spi5_seq_pkg::st_xfer;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("ready not ignored after late drop");

	property p_no_slave_error_a;
		!t2e_on |-> !slave_error_a_set;
	endproperty
	a_no_slave_error_a: assert property (p_no_slave_error_a)
		else $error("slave_error_a set with delay absent");

	property p_c2t_full;
		s_c2t_leave |->
			age_r == dly_width'(select_to_xfer_start_delay - 1'b1);
	endproperty
	a_c2t_full: assert property (p_c2t_full)
		else $error("select to transfer delay cut short");

	property p_c2e_end;
		state_r == spi5_seq_pkg::st_c2e && ready_s
			|=> state_r == spi5_seq_pkg::st_xfer;
	endproperty
	a_c2e_end: assert property (p_c2e_end)
		else $error("ready wait not ended by ready");

	property p_timeout;
		s_c2e_expire |=> timeout_error && slave_select_out_n &&
			!seq_busy;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("timeout not handled");

	property p_no_timeout;
		!c2e_on |-> !timeout_set;
	endproperty
	a_no_timeout: assert property (p_no_timeout)
		else $error("timeout set with limit absent");
endmodule

// ==== sim/spi5_slave_model.sv ====
// spi5_slave_model: slave side of the five-pin ready handshake
// assumes: serial clock idles low, a word is xfer_bits falling edges
`timescale 1ns/10ps
module spi5_slave_model
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// behaviour
	input  wire logic       hold_low,
	input  wire logic [9:0] drop_wait,
	input  wire logic [9:0] rise_wait,
	// pins
	input  wire logic       serial_clock_pin,
	output logic            slave_ready_line
);
	int   falls = 0;
	logic ready_r = 1'b1;
	event word_end;

	assign slave_ready_line = ready_r & ~hold_low;

	// word end on the last falling serial edge
	always @(negedge serial_clock_pin)
	begin
		if (reset !== 1'b0)
			falls = 0;
		else if (falls == spi5_seq_pkg::xfer_bits - 1)
		begin
			falls = 0;
			-> word_end;
		end
		else
			falls++;
	end

	// ready drops after each word, returns when prepared
	always @(word_end)
	begin
		repeat (drop_wait) @(negedge clock);
		ready_r = 1'b0;
		repeat (rise_wait) @(negedge clock);
		ready_r = 1'b1;
	end
endmodule

// ==== sim/test_spi5_seq.sv ====
// test_spi5_seq: row-driven bench for the five-pin sequencer
// assumes: slave model answers ready; inputs change on falling edges
`timescale 1ns/10ps
module test_spi5_seq;
	typedef struct
	{
		logic [7:0] t2c;
		logic [7:0] t2e;
		logic       t2e_en;
		logic [7:0] wd;
		logic [9:0] drop;
		logic       exp_err;
		logic       exp_rdy;
	} row_t;

	row_t       rows [6] = '{
		'{8'h02, 8'h02, 1'b1, 8'h02, 10'h028, 1'b1, 1'b0},
		'{8'h02, 8'h02, 1'b0, 8'h02, 10'h028, 1'b0, 1'b0},
		'{8'h02, 8'h00, 1'b1, 8'h02, 10'h028, 1'b0, 1'b0},
		'{8'h0a, 8'h14, 1'b1, 8'h02, 10'h002, 1'b0, 1'b1},
		'{8'h02, 8'h1e, 1'b1, 8'h02, 10'h00c, 1'b0, 1'b1},
		'{8'h02, 8'h02, 1'b1, 8'h28, 10'h00f, 1'b1, 1'b1}};
	logic       clock = 1'b0;
	logic       link_clock = 1'b0;
	logic       reset = 1'b1;
	logic [7:0] c2t = 8'h03;
	logic       c2t_en = 1'b1;
	logic [7:0] c2e = 8'h32;
	logic       c2e_en = 1'b1;
	logic [7:0] t2c = 8'h02;
	logic       t2c_en = 1'b1;
	logic [7:0] t2e = 8'h02;
	logic       t2e_en = 1'b1;
	logic [7:0] wd = 8'h02;
	logic       wd_en = 1'b1;
	logic       xfer_req = 1'b0;
	logic       error_clear = 1'b0;
	logic       hold_low = 1'b0;
	logic [9:0] drop_wait = 10'h002;
	logic [9:0] rise_wait = 10'h0c8;
	logic       slave_ready_line;
	logic       xfer_pending;
	logic       xfer_done;
	logic       seq_busy;
	logic       slave_error_a;
	logic       timeout_error;
	logic       slave_select_out_n;
	logic       serial_clock_pin;
	int         fails = 0;
	int         tests_run = 0;
	int         dones = 0;
	int         d0 = 0;
	int         hold_cnt = -1;
	int         hold_seen = 0;
	int         rises = 0;
	int         r0 = 0;

	always #20 clock = ~clock;

	// serial clock rising edges
	always @(posedge serial_clock_pin)
		rises++;

	initial
	begin
		#2.5;
		forever #6 link_clock = ~link_clock;
	end

	spi5_seq i_spi5_seq
	(
		.clock                               (clock),
		.reset                               (reset),
		.link_clock                          (link_clock),
		.select_to_xfer_start_delay          (c2t),
		.select_to_xfer_start_delay_en       (c2t_en),
		.select_to_ready_wait_limit          (c2e),
		.select_to_ready_wait_limit_en       (c2e_en),
		.xfer_end_to_select_release_delay    (t2c),
		.xfer_end_to_select_release_delay_en (t2c_en),
		.xfer_end_to_ready_drop_delay        (t2e),
		.xfer_end_to_ready_drop_delay_en     (t2e_en),
		.inter_word_delay                    (wd),
		.inter_word_delay_en                 (wd_en),
		.xfer_req                            (xfer_req),
		.xfer_pending                        (xfer_pending),
		.xfer_done                           (xfer_done),
		.seq_busy                            (seq_busy),
		.error_clear                         (error_clear),
		.slave_error_a                       (slave_error_a),
		.timeout_error                       (timeout_error),
		.slave_ready_line                    (slave_ready_line),
		.slave_select_out_n                  (slave_select_out_n),
		.serial_clock_pin                    (serial_clock_pin)
	);

	spi5_slave_model i_spi5_slave_model
	(
		.clock            (clock),
		.reset            (reset),
		.hold_low         (hold_low),
		.drop_wait        (drop_wait),
		.rise_wait        (rise_wait),
		.serial_clock_pin (serial_clock_pin),
		.slave_ready_line (slave_ready_line)
	);

	// word count and select hold after each word
	always @(negedge clock)
	begin
		if (xfer_done === 1'b1)
		begin
			dones++;
			hold_cnt = 0;
		end
		else if (slave_select_out_n === 1'b0 && hold_cnt >= 0)
			hold_cnt++;
		else if (hold_cnt >= 0)
		begin
			hold_seen = hold_cnt;
			hold_cnt = -1;
		end
	end

	task automatic stop_test();
		$display("tests_run %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic probe(input int which);
		case (which)
			0: return seq_busy;
			1: return slave_select_out_n;
			2: return timeout_error;
			default: return slave_ready_line;
		endcase
	endfunction

	task automatic wait_for(input int which, input logic lvl, input int lim);
		int n;
		n = 0;
		while (probe(which) !== lvl && n < lim)
		begin
			@(negedge clock);
			n++;
		end
		if (n >= lim)
		begin
			fails++;
			$display("[ERR] wait %0d expected %b seen %b", which, lvl,
				probe(which));
			stop_test();
		end
	endtask

	task automatic pulse(input logic is_clear);
		if (is_clear)
			error_clear = 1'b1;
		else
			xfer_req = 1'b1;
		@(negedge clock);
		if (is_clear)
			error_clear = 1'b0;
		else
			xfer_req = 1'b0;
	endtask

	initial
	begin
		repeat (5) @(negedge clock);
		reset = 1'b0;
		@(negedge clock);
		check("select_n", slave_select_out_n, 8'h01);
		check("flags", {seq_busy, slave_error_a, timeout_error},
			8'h00);
		for (int i = 0; i < 6; i++)
		begin
			t2c = rows[i].t2c;
			t2e = rows[i].t2e;
			t2e_en = rows[i].t2e_en;
			wd = rows[i].wd;
			drop_wait = rows[i].drop;
			pulse(1'b1);
			check("slave_error_a clear", slave_error_a, 8'h00);
			d0 = dones;
			r0 = rises;
			pulse(1'b0);
			wait_for(0, 1'b1, 20);
			wait_for(0, 1'b0, 500);
			check("words", dones - d0, 8'h01);
			check("clocks", rises - r0,
				8'(spi5_seq_pkg::xfer_bits));
			check("slave_error_a", slave_error_a,
				rows[i].exp_err);
			check("hold", 8'(hold_seen + 1), rows[i].t2c);
			repeat (60) @(negedge clock);
			pulse(1'b0);
			wait_for(1, 1'b0, 600);
			check("ready", slave_ready_line, rows[i].exp_rdy);
			wait_for(0, 1'b0, 600);
			repeat (300) @(negedge clock);
			wait_for(3, 1'b1, 300);
		end
		// ready drops in the select delay, stays low through the limit
		c2e = 8'h0a;
		d0 = dones;
		r0 = rises;
		repeat (3) @(negedge clock);
		pulse(1'b0);
		hold_low = 1'b1;
		wait_for(2, 1'b1, 100);
		check("select", slave_select_out_n, 8'h01);
		check("pending", xfer_pending, 8'h00);
		repeat (20) @(negedge clock);
		check("no word", dones - d0, 8'h00);
		check("no clocks", rises - r0, 8'h00);
		// no wait limit: waits as long as ready stays low
		c2e_en = 1'b0;
		hold_low = 1'b0;
		pulse(1'b1);
		repeat (3) @(negedge clock);
		pulse(1'b0);
		hold_low = 1'b1;
		repeat (300) @(negedge clock);
		check("timeout", timeout_error, 8'h00);
		check("waiting", slave_select_out_n, 8'h00);
		hold_low = 1'b0;
		wait_for(0, 1'b0, 500);
		check("late word", dones - d0, 8'h01);
		// ready arrives inside the wait limit
		repeat (300) @(negedge clock);
		c2e = 8'h64;
		c2e_en = 1'b1;
		pulse(1'b0);
		hold_low = 1'b1;
		repeat (40) @(negedge clock);
		check("select held", slave_select_out_n, 8'h00);
		hold_low = 1'b0;
		wait_for(0, 1'b0, 500);
		check("word", dones - d0, 8'h02);
		check("timeout", timeout_error, 8'h00);
		stop_test();
	end
endmodule
